// ===== bench/psc_ctrl_model.sv
// Memory-controller model that drives the synchronous pins and write data
`timescale 1ns/1ps
module psc_ctrl_model (
    // Clock and qualify
    input  wire logic                           clk_sys,
    input  wire logic                           clockQualifyN,
    input  wire logic                           acceptReady,
    // Pins towards the block
    output psc_pkg::psc_pins_s                  pins,
    output logic [psc_pkg::PSC_DATA_W-1:0]      dataIn
);
    import psc_pkg::*;
    logic                  curWr = 1'h0;
    logic [PSC_DATA_W-1:0] curData = '0;
    logic [PSC_DATA_W-1:0] dataNext = '0;
    initial dataIn = '0;
    initial pins = '{addr: '0, byteLaneWriteSelectN: 4'hF, writeStrobeN: 1'h1, advanceOrLoad: 1'h0,
                     chipSelectFirstN: 1'h1, chipSelectSecond: 1'h0, chipSelectThirdN: 1'h1};

    task automatic put(input logic [2:0] cs, input logic adv, input logic wr,
                       input logic [PSC_ADDR_W-1:0] a, input logic [PSC_LANES-1:0] bw,
                       input logic [PSC_DATA_W-1:0] d);
        pins = '{addr: a, byteLaneWriteSelectN: bw, writeStrobeN: !wr, advanceOrLoad: adv,
                 chipSelectFirstN: cs[2], chipSelectSecond: cs[1], chipSelectThirdN: cs[0]};
        curWr = wr;
        curData = d;
    endtask : put

    // Deselected pins keep advance low so the next access loads afresh
    task automatic rest();
        put(3'h4, 1'h0, 1'h0, ~pins.addr, 4'hF, ~curData);
    endtask : rest

    // Hold the request until a qualified edge takes it
    task automatic wait_taken(output logic ok);
        int n;
        ok = 1'h0;
        for (n = 0; n < 64 && !ok; n++) begin
            @(posedge clk_sys);
            ok = !clockQualifyN && acceptReady;
        end
        #1;
    endtask : wait_taken

    // Data follows two qualified edges later; idle lanes toggle so stale data never matches
    always @(posedge clk_sys) begin
        if (!clockQualifyN && acceptReady) begin
            dataNext <= curWr ? curData : ~dataNext;
            dataIn   <= dataNext;
        end
    end
endmodule : psc_ctrl_model

// ===== bench/test_pipelined_sram_control_pins.sv
// Self-checking testbench for the SRAM control-pin block
`timescale 1ns/1ps
module test_pipelined_sram_control_pins;
    import psc_pkg::*;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic                  clk_sys = 1'h0;
    logic                  rst_n = 1'h0;
    psc_pins_s             pins;
    logic                  clockQualifyN = 1'h0;
    logic                  burstOrderStrap = 1'h1;
    logic [PSC_DATA_W-1:0] dataIn;
    logic                  outputDriveN = 1'h0;
    logic                  dataOutEnable, deviceSelected, writeDataPhase, acceptReady, cmdValid;
    logic                  cmdReady = 1'h0;
    psc_cmd_s              cmdOut, expCmd;
    psc_cmd_s              expQ[$];
    int                    nMismatch = 0;
    int                    nCompared = 0;
    logic [31:0]           rnd = 32'h12931767;
    logic [31:0]           drnRnd = 32'h12931767;
    logic                  drainOn = 1'h1;
    logic                  selNow, opWr, il, rAdv;
    logic [PSC_ADDR_W-1:0] baseA;
    logic [1:0]            cnt;
    logic [2:0]            rCs;

    always #50 clk_sys = ~clk_sys;

    psc_sram_ctrl #(.FIFO_DEPTH(PSC_FIFO_DEPTH)) psc_sram_ctrl_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .pins(pins), .clockQualifyN(clockQualifyN),
        .burstOrderStrap(burstOrderStrap), .dataIn(dataIn), .outputDriveN(outputDriveN),
        .dataOutEnable(dataOutEnable), .deviceSelected(deviceSelected), .writeDataPhase(writeDataPhase),
        .acceptReady(acceptReady), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOut(cmdOut));

    psc_ctrl_model psc_ctrl_model_i (
        .clk_sys(clk_sys), .clockQualifyN(clockQualifyN), .acceptReady(acceptReady),
        .pins(pins), .dataIn(dataIn));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic [PSC_ADDR_W-1:0] beatAddr(input logic [PSC_ADDR_W-1:0] b,
                                                       input logic [1:0] c, input logic i);
        logic [1:0] low;
        low = i ? (b[1:0] ^ c) : 2'(b[1:0] + c);
        return {b[PSC_ADDR_W-1:2], low};
    endfunction : beatAddr

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        nCompared++;
        if (seen !== exp) begin
            nMismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic stopTest();
        $display("compared %0d mismatched %0d", nCompared, nMismatch);
        if (nMismatch == 0 && nCompared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stopTest

    task automatic failWait(input string what);
        nMismatch++;
        $display("CHECK FAILED %s expected done seen timeout", what);
        stopTest();
    endtask : failWait

    // Predicts the access, then lets the controller model present it
    task automatic acc(input logic [2:0] cs, input logic adv, input logic wr,
                       input logic [PSC_ADDR_W-1:0] a, input logic [PSC_LANES-1:0] bw);
        logic [PSC_DATA_W-1:0] d;
        logic                  ok;
        repeat (8) rnd = lfsr(rnd);
        d = {rnd[3:0], lfsr(rnd)};
        if (!adv && cs == 3'h2) begin
            baseA = a;
            cnt = 2'h0;
            opWr = wr;
            expQ.push_back('{wr, a, wr ? ~bw : 4'h0, d});
        end else if (adv && selNow && cs == 3'h2) begin
            cnt = cnt + 2'h1;
            expQ.push_back('{opWr, beatAddr(baseA, cnt, il), opWr ? ~bw : 4'h0, d});
        end
        selNow = adv ? (selNow && cs == 3'h2) : (cs == 3'h2);
        psc_ctrl_model_i.put(cs, adv, adv ? opWr : wr, a, bw, d);
        psc_ctrl_model_i.wait_taken(ok);
        if (!ok) failWait("pin edge");
        check("selected", 64'(deviceSelected), 64'(selNow));
    endtask : acc

    task automatic idle(input int n);
        logic ok;
        repeat (n) begin
            psc_ctrl_model_i.rest();
            psc_ctrl_model_i.wait_taken(ok);
            if (!ok) failWait("idle edge");
            selNow = 1'h0;
        end
    endtask : idle

    task automatic burst(input logic wr, input int n);
        acc(3'h2, 1'h0, wr, rnd[17:0], rnd[25:22]);
        for (int i = 0; i < n; i++) begin
            acc(3'h2, 1'h1, wr, rnd[17:0], rnd[25:22]);
        end
    endtask : burst

    task automatic drainAll();
        int n;
        psc_ctrl_model_i.rest();
        selNow = 1'h0;
        drainOn = 1'h1;
        for (n = 0; n < 400 && (expQ.size() > 0 || cmdValid !== 1'h0); n++) @(posedge clk_sys);
        #1;
        if (n >= 400) failWait("drain");
    endtask : drainAll

    task automatic doReset(input logic strap);
        psc_ctrl_model_i.rest();
        rst_n = 1'h0;
        burstOrderStrap = strap;
        il = strap;
        selNow = 1'h0;
        expQ.delete();
        repeat (12) @(posedge clk_sys);
        #1;
        check("ready in reset", 64'(acceptReady), 64'h1);
        check("valid in reset", 64'(cmdValid), 64'h0);
        check("drive in reset", 64'(dataOutEnable), 64'h0);
        rst_n = 1'h1;
    endtask : doReset

    // ----------------------------------------------------------------
    // Drain side: random stalls, entries compared in order
    // ----------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rst_n && cmdValid === 1'h1 && cmdReady) begin
            expCmd = (expQ.size() > 0) ? expQ.pop_front() : '1;
            check("write flag", 64'(cmdOut.write), 64'(expCmd.write));
            check("address", 64'(cmdOut.addr), 64'(expCmd.addr));
            check("lanes", 64'(cmdOut.lanes), 64'(expCmd.lanes));
            if (expCmd.write) check("data", 64'(cmdOut.data), 64'(expCmd.data));
        end
        drnRnd = lfsr(drnRnd);
        cmdReady <= #1 drainOn & (drnRnd[0] | drnRnd[3]);
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        doReset(1'h1);
        burst(1'h1, 4);
        burst(1'h0, 4);
        for (int k = 0; k < 8; k++) begin
            acc(3'(k), 1'h0, 1'h0, rnd[17:0], 4'hF);
            if (k == 3) check("drive deselected read", 64'(dataOutEnable), 64'h0);
        end
        idle(2);
        acc(3'h2, 1'h0, 1'h0, rnd[17:0], 4'hF);
        check("drive first clock", 64'(dataOutEnable), 64'h0);
        acc(3'h2, 1'h1, 1'h0, rnd[17:0], 4'hF);
        check("drive read", 64'(dataOutEnable), 64'h1);
        outputDriveN = 1'h1;
        #1;
        check("drive off", 64'(dataOutEnable), 64'h0);
        outputDriveN = 1'h0;
        acc(3'h2, 1'h0, 1'h1, rnd[17:0], rnd[3:0]);
        acc(3'h2, 1'h1, 1'h1, rnd[17:0], rnd[7:4]);
        check("write phase", 64'(writeDataPhase), 64'h1);
        check("drive in write", 64'(dataOutEnable), 64'h0);
        idle(2);
        check("drive deselected", 64'(dataOutEnable), 64'h0);
        burst(1'h0, 1);
        clockQualifyN = 1'h1;
        psc_ctrl_model_i.put(3'h2, 1'h0, 1'h1, rnd[17:0], 4'h0, '0);
        repeat (5) @(posedge clk_sys);
        #1;
        check("frozen selected", 64'(deviceSelected), 64'h1);
        check("strobe masked", 64'(writeDataPhase), 64'h0);
        psc_ctrl_model_i.rest();
        clockQualifyN = 1'h0;
        idle(1);
        for (int i = 0; i < 40; i++) begin
            rCs = (rnd[5:4] == 2'h0) ? rnd[8:6] : 3'h2;
            rAdv = selNow & rnd[9];
            acc(rCs, rAdv, rnd[10], rnd[27:10], rnd[14:11]);
        end
        drainAll();
        drainOn = 1'h0;
        for (int i = 0; i < 4; i++) begin
            acc(3'h2, 1'(i > 0), 1'h0, rnd[17:0], 4'hF);
        end
        idle(2);
        repeat (3) @(posedge clk_sys);
        #1;
        check("fifo full", 64'(acceptReady), 64'h0);
        check("fifo held", 64'(cmdValid), 64'h1);
        drainAll();
        doReset(1'h0);
        burst(1'h1, 4);
        burst(1'h0, 4);
        drainAll();
        stopTest();
    end
endmodule : test_pipelined_sram_control_pins

// ===== common/psc_pkg.sv
// Shared constants, types and helpers for the pipelined SRAM control-pin block
package psc_pkg;

    // ----------------------------------------------------------------
    // Widths and depths
    // ----------------------------------------------------------------
    localparam int PSC_ADDR_W     = 18;
    localparam int PSC_LANES      = 4;
    localparam int PSC_LANE_BITS  = 9;
    localparam int PSC_DATA_W     = PSC_LANES * PSC_LANE_BITS;
    localparam int PSC_BURST_W    = 2;
    localparam int PSC_FIFO_DEPTH = 4;

    // ----------------------------------------------------------------
    // Reset values and counts
    // ----------------------------------------------------------------
    localparam logic [PSC_BURST_W-1:0] PSC_CNT_RESET     = 2'h0;
    localparam logic [PSC_BURST_W-1:0] PSC_CNT_STEP      = 2'h1;
    localparam logic                   PSC_STRAP_DEFAULT = 1'h1;
    localparam logic [PSC_LANES-1:0]   PSC_NO_LANES      = 4'h0;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PSC_SEQ_DESEL = 2'h0,
        PSC_SEQ_FIRST = 2'h1,
        PSC_SEQ_BURST = 2'h3
    } psc_seq_e;

    typedef struct packed {
        logic [PSC_ADDR_W-1:0] addr;
        logic [PSC_LANES-1:0]  byteLaneWriteSelectN;
        logic                  writeStrobeN;
        logic                  advanceOrLoad;
        logic                  chipSelectFirstN;
        logic                  chipSelectSecond;
        logic                  chipSelectThirdN;
    } psc_pins_s;

    typedef struct packed {
        logic                  valid;
        logic                  write;
        logic [PSC_ADDR_W-1:0] addr;
        logic [PSC_LANES-1:0]  lanes;
    } psc_access_s;

    typedef struct packed {
        logic                  write;
        logic [PSC_ADDR_W-1:0] addr;
        logic [PSC_LANES-1:0]  lanes;
        logic [PSC_DATA_W-1:0] data;
    } psc_cmd_s;

    localparam psc_access_s PSC_ACCESS_IDLE = '0;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [PSC_BURST_W-1:0] psc_burst_low(
        input logic [PSC_BURST_W-1:0] base,
        input logic [PSC_BURST_W-1:0] count,
        input logic                   interleave
    );
        psc_burst_low = interleave ? (base ^ count) : PSC_BURST_W'(base + count);
    endfunction : psc_burst_low

endpackage : psc_pkg

// ===== design/psc_fifo.sv
// Small parameterised FIFO with valid/ready on both sides
`timescale 1ns/1ps
module psc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    // Fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] memReg [DEPTH];
    logic [PTR_W-1:0] wrPtrReg;
    logic [PTR_W-1:0] rdPtrReg;
    logic [CNT_W-1:0] countReg;
    logic             doPush;
    logic             doPop;

    // ----------------------------------------------------------------
    // Handshake
    // ----------------------------------------------------------------
    assign inReady  = (countReg != CNT_W'(DEPTH));
    assign outValid = (countReg != '0);
    assign outData  = memReg[rdPtrReg];
    assign doPush   = inValid && inReady;
    assign doPop    = outValid && outReady;

    function automatic logic [PTR_W-1:0] nextPtr(input logic [PTR_W-1:0] p);
        nextPtr = (p == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(p + 1'b1);
    endfunction : nextPtr

    // ----------------------------------------------------------------
    // Storage and pointers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (doPush) begin
            memReg[wrPtrReg] <= inData;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wrPtrReg <= '0;
            rdPtrReg <= '0;
            countReg <= '0;
        end else begin
            if (doPush) begin
                wrPtrReg <= nextPtr(wrPtrReg);
            end
            if (doPop) begin
                rdPtrReg <= nextPtr(rdPtrReg);
            end
            countReg <= CNT_W'(countReg + CNT_W'(doPush) - CNT_W'(doPop));
        end
    end

endmodule : psc_fifo

// ===== design/psc_sram_ctrl.sv
// Synchronous control-pin front end of a pipelined burst SRAM
`timescale 1ns/1ps
module psc_sram_ctrl #(
    parameter int FIFO_DEPTH = psc_pkg::PSC_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rst_n,
    // Synchronous control pins
    input  wire psc_pkg::psc_pins_s pins,
    input  wire logic               clockQualifyN,
    input  wire logic               burstOrderStrap,
    // Data lanes and output drive control
    input  wire logic [psc_pkg::PSC_DATA_W-1:0] dataIn,
    input  wire logic               outputDriveN,
    output logic                    dataOutEnable,
    // Status
    output logic                    deviceSelected,
    output logic                    writeDataPhase,
    output logic                    acceptReady,
    // Access stream towards the array
    output logic                    cmdValid,
    input  wire logic               cmdReady,
    output psc_pkg::psc_cmd_s       cmdOut
);
    import psc_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    psc_seq_e                seqReg;
    psc_seq_e                seqNext;
    psc_access_s             stage1Reg;
    psc_access_s             stage2Reg;
    psc_access_s             accessNext;
    logic [PSC_ADDR_W-1:0]   baseReg;
    logic [PSC_BURST_W-1:0]  cntReg;
    logic [PSC_BURST_W-1:0]  cntNext;
    logic                    lastWriteReg;
    logic                    interleaveReg;
    logic                    strapTakenReg;
    logic                    qualEdge;
    logic                    selNow;
    logic                    loadNow;
    logic                    advNow;
    logic                    fifoInReady;
    logic                    fifoPush;
    psc_cmd_s                fifoInData;

    // ----------------------------------------------------------------
    // Edge qualification
    // ----------------------------------------------------------------
    // A full access queue stalls the pins exactly like a masked clock,
    // so nothing is ever dropped; the controller sees acceptReady low.
    assign qualEdge    = !clockQualifyN && fifoInReady;
    assign acceptReady = fifoInReady;

    // ----------------------------------------------------------------
    // Select and access decode
    // ----------------------------------------------------------------
    assign selNow  = !pins.chipSelectFirstN && pins.chipSelectSecond
                     && !pins.chipSelectThirdN;
    assign loadNow = selNow && !pins.advanceOrLoad;
    // Advancing straight out of deselect has nothing to continue
    assign advNow  = selNow && pins.advanceOrLoad && (seqReg != PSC_SEQ_DESEL);

    always_comb begin
        cntNext = loadNow ? PSC_CNT_RESET : PSC_BURST_W'(cntReg + PSC_CNT_STEP);
        accessNext       = PSC_ACCESS_IDLE;
        accessNext.valid = loadNow || advNow;
        accessNext.write = loadNow ? !pins.writeStrobeN : lastWriteReg;
        if (loadNow) begin
            accessNext.addr = pins.addr;
        end else begin
            accessNext.addr = {baseReg[PSC_ADDR_W-1:PSC_BURST_W],
                               psc_burst_low(baseReg[PSC_BURST_W-1:0], cntNext, interleaveReg)};
        end
        accessNext.lanes = accessNext.write ? ~pins.byteLaneWriteSelectN : PSC_NO_LANES;
        if (!accessNext.valid) begin
            accessNext = PSC_ACCESS_IDLE;
        end
    end

    // ----------------------------------------------------------------
    // Sequence state
    // ----------------------------------------------------------------
    always_comb begin
        case (seqReg)
            PSC_SEQ_DESEL: begin
                seqNext = loadNow ? PSC_SEQ_FIRST : PSC_SEQ_DESEL;
            end
            PSC_SEQ_FIRST, PSC_SEQ_BURST: begin
                seqNext = selNow ? PSC_SEQ_BURST : PSC_SEQ_DESEL;
            end
            default: begin
                seqNext = PSC_SEQ_DESEL;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            seqReg <= PSC_SEQ_DESEL;
        end else if (qualEdge) begin
            seqReg <= seqNext;
        end
    end

    // ----------------------------------------------------------------
    // Burst counter
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            baseReg      <= '0;
            cntReg       <= PSC_CNT_RESET;
            lastWriteReg <= 1'b0;
        end else if (qualEdge && (loadNow || advNow)) begin
            if (loadNow) begin
                baseReg      <= pins.addr;
                lastWriteReg <= !pins.writeStrobeN;
            end
            cntReg <= cntNext;
        end
    end

    // ----------------------------------------------------------------
    // Burst order strap
    // ----------------------------------------------------------------
    // Taken once after reset; the strap is not meant to move later
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            interleaveReg <= PSC_STRAP_DEFAULT;
            strapTakenReg <= 1'b0;
        end else if (!strapTakenReg) begin
            interleaveReg <= burstOrderStrap;
            strapTakenReg <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Address and data pipeline
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            stage1Reg <= PSC_ACCESS_IDLE;
            stage2Reg <= PSC_ACCESS_IDLE;
        end else if (qualEdge) begin
            stage1Reg <= accessNext;
            stage2Reg <= stage1Reg;
        end
    end

    // The data phase edge pairs the access with the lanes' contents
    assign fifoPush         = qualEdge && stage2Reg.valid;
    assign fifoInData.write = stage2Reg.write;
    assign fifoInData.addr  = stage2Reg.addr;
    assign fifoInData.lanes = stage2Reg.lanes;
    assign fifoInData.data  = dataIn;

    psc_fifo #(
        .WIDTH ($bits(psc_cmd_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .inValid  (fifoPush),
        .inReady  (fifoInReady),
        .inData   (fifoInData),
        .outValid (cmdValid),
        .outReady (cmdReady),
        .outData  (cmdOut)
    );

    // ----------------------------------------------------------------
    // Output drive and status
    // ----------------------------------------------------------------
    // The drive input is asynchronous, so it passes straight through;
    // the masking terms all come from flip-flops to avoid glitches.
    assign dataOutEnable  = !outputDriveN
                            && (seqReg == PSC_SEQ_BURST)
                            && stage2Reg.valid && !stage2Reg.write;
    assign deviceSelected = (seqReg != PSC_SEQ_DESEL);
    assign writeDataPhase = stage2Reg.valid && stage2Reg.write;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    a_stall_freeze_state: assert property (
        clockQualifyN |=> $stable(seqReg) && $stable(stage1Reg) && $stable(cntReg))
        else $error("state moved on an unqualified edge");

    a_select_combo_decode: assert property (
        qualEdge && !selNow |=> seqReg == PSC_SEQ_DESEL)
        else $error("device not deselected by a bad select combination");

    a_load_takes_addr: assert property (
        qualEdge && loadNow |=> stage1Reg.valid && stage1Reg.addr == $past(pins.addr)
                                && cntReg == PSC_CNT_RESET)
        else $error("load did not capture the presented address");

    a_advance_steps_count: assert property (
        qualEdge && advNow |=> cntReg == PSC_BURST_W'($past(cntReg) + PSC_CNT_STEP)
                               && stage1Reg.addr[PSC_ADDR_W-1:PSC_BURST_W]
                                  == baseReg[PSC_ADDR_W-1:PSC_BURST_W])
        else $error("advance did not step the burst counter within its group");

    a_write_lane_select: assert property (
        qualEdge && loadNow && !pins.writeStrobeN
        |=> stage1Reg.write && stage1Reg.lanes == ~$past(pins.byteLaneWriteSelectN))
        else $error("write lanes do not follow the lane selects");

    a_read_no_lanes: assert property (
        qualEdge && loadNow && pins.writeStrobeN |=> !stage1Reg.write && stage1Reg.lanes == PSC_NO_LANES)
        else $error("read access carries write lanes");

    // Assertion helper: ages each access by qualified edges, apart from the stage registers
    logic [1:0] chkAgeReg;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            chkAgeReg <= '0;
        end else if (qualEdge) begin
            chkAgeReg <= {chkAgeReg[0], accessNext.valid};
        end
    end

    a_data_two_edges: assert property (
        qualEdge |-> fifoPush == chkAgeReg[1])
        else $error("access not pushed at its data phase");

    a_oe_masked_cases: assert property (
        (seqReg != PSC_SEQ_BURST) || writeDataPhase || outputDriveN |-> !dataOutEnable)
        else $error("outputs driven while they must be off");

    a_oe_drive_follows: assert property (
        seqReg == PSC_SEQ_BURST && stage2Reg.valid && !stage2Reg.write
        |-> dataOutEnable == !outputDriveN)
        else $error("output enable ignores the drive input on a read");

    c_write_load: cover property (qualEdge && loadNow && !pins.writeStrobeN ##1 qualEdge [*2] ##0 fifoPush);
    c_burst_four: cover property ((qualEdge && advNow) [*3]);
    c_stall_fifo_full: cover property (!clockQualifyN && !fifoInReady);
    c_read_drive: cover property (dataOutEnable);

endmodule : psc_sram_ctrl
